/* inc/bps_pkg.sv */
package bps_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int ClockHz = 25000000;
  localparam int OvDelayNs = 5000;  // overvoltage qualification time
  // longest wait rounded down, here 125 cycles
  localparam int OvDelayCycles = (OvDelayNs * (ClockHz / 1000000)) / 1000;
  localparam int HiccupCycles = 4000;  // blanking interval in cycles
  localparam int PeriodWidth = 8;  // switching period counter width

  // ****************************************************
  // voltage codes in 1/1024 V units
  // ****************************************************
  localparam logic [15:0] Mv600 = 16'h0266;   // 0.6 V
  localparam logic [15:0] Mv700 = 16'h02cd;   // 0.7 V
  localparam logic [15:0] Mv800 = 16'h0333;   // 0.8 V
  localparam logic [15:0] Mv850 = 16'h0366;   // 0.85 V
  localparam logic [15:0] Mv900 = 16'h039a;   // 0.9 V
  localparam logic [15:0] Mv1100 = 16'h0466;  // 1.1 V
  localparam logic [15:0] Mv1200 = 16'h04cd;  // 1.2 V

  // ****************************************************
  // switching periods in clock cycles, 25 MHz / fsw
  // ****************************************************
  localparam logic [7:0] Per1500 = 8'h11;  // 1.5 MHz
  localparam logic [7:0] Per1250 = 8'h14;  // 1.25 MHz
  localparam logic [7:0] Per1040 = 8'h18;  // 1.04 MHz
  localparam logic [7:0] Per892 = 8'h1c;   // 0.892 MHz
  localparam logic [7:0] Per781 = 8'h20;   // 0.781 MHz
  localparam logic [7:0] Per694 = 8'h24;   // 0.694 MHz
  localparam logic [7:0] Per625 = 8'h28;   // 0.625 MHz
  localparam logic [7:0] Per568 = 8'h2c;   // 0.568 MHz
  localparam logic [7:0] MinOnCycles = 8'h02;  // minimum on-time

  // ****************************************************
  // phase offsets in tenths of a degree
  // ****************************************************
  localparam logic [11:0] Ph180 = 12'h708;
  localparam logic [11:0] Ph120 = 12'h4b0;
  localparam logic [11:0] Ph90 = 12'h384;
  localparam logic [11:0] Ph72 = 12'h2d0;
  localparam logic [11:0] Ph60 = 12'h258;
  localparam logic [11:0] Ph514 = 12'h202;
  localparam logic [11:0] Ph45 = 12'h1c2;

  // ****************************************************
  // overcurrent limit in 0.5 A steps, overvoltage steps
  // ****************************************************
  localparam logic [6:0] OcMaxCode = 7'h4b;  // 37.5 A
  localparam logic [1:0] OvSel120 = 2'h3;    // reset threshold
  // percentage limits in tenths of a percent
  localparam logic [11:0] OvPct1054 = 12'h41e;
  localparam logic [11:0] OvPct1101 = 12'h44d;
  localparam logic [11:0] OvPct1148 = 12'h47c;

  typedef enum logic [2:0] {
    BpsOff, BpsRun, BpsOcDrain, BpsHiccup, BpsLatched
  } bps_state_e;

endpackage : bps_pkg

/* inc/bps_pwm_if.sv */
`timescale 1ns/1ps
// control bundle between supervisor and pulse generator
interface bps_pwm_if;
  logic run;                  // conversion allowed
  logic startup;              // soft-start low output phase
  logic [7:0] period;         // switching period in cycles
  logic [7:0] duty;           // requested on-time in cycles
  logic forceSyncOn;          // hold sync switches on
  logic killAll;              // every switch off
  modport sup (output run, startup, period, duty, forceSyncOn, killAll);
  modport gen (input run, startup, period, duty, forceSyncOn, killAll);
endinterface : bps_pwm_if

/* src/bps_pwm_gen.sv */
`timescale 1ns/1ps
// two-phase interleaved pulse generator
module bps_pwm_gen (
  input wire logic clock,
  input wire logic rst,
  bps_pwm_if.gen ctl,
  output logic hsOn1,
  output logic hsOn2,
  output logic lsOn1,
  output logic lsOn2
);

  logic [7:0] cnt_reg;   // position in the switching period
  logic [7:0] half;      // start of the second phase
  logic [7:0] onLen;     // on-time actually used
  logic on1;
  logic on2;

  // ****************************************************
  // period counter
  // ****************************************************
  // free-running counter; restarts when the period shrinks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
    end else if (!ctl.run || cnt_reg >= ctl.period - 8'h01) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // ****************************************************
  // on-time limiting
  // ****************************************************
  always_comb begin
    half = {1'b0, ctl.period[7:1]};
    if (ctl.startup) begin
      onLen = bps_pkg::MinOnCycles;
    end else if (ctl.duty >= half) begin
      // keep one cycle gap so the high sides never touch
      onLen = half - 8'h01;
    end else begin
      onLen = ctl.duty;
    end
    on1 = cnt_reg < onLen;
    on2 = (cnt_reg >= half) && (cnt_reg < half + onLen);
  end

  // ****************************************************
  // gate outputs, registered
  // ****************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hsOn1 <= 1'b0;
      hsOn2 <= 1'b0;
      lsOn1 <= 1'b0;
      lsOn2 <= 1'b0;
    end else if (ctl.killAll || !ctl.run) begin
      hsOn1 <= 1'b0;
      hsOn2 <= 1'b0;
      lsOn1 <= ctl.forceSyncOn;
      lsOn2 <= ctl.forceSyncOn;
    end else begin
      hsOn1 <= on1;
      hsOn2 <= on2 && !on1;
      lsOn1 <= !on1;
      lsOn2 <= !on2;
    end
  end

endmodule : bps_pwm_gen

/* src/bps_supervisor.sv */
`timescale 1ns/1ps
// supervisor: strap decode, enable, overcurrent and overvoltage
module bps_supervisor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] phaseStrapInput,
  input wire logic enablePin,
  input wire logic latchOnOc,
  input wire logic [6:0] ocLimitCode,
  input wire logic ocSense,
  input wire logic syncCurrentZero,
  input wire logic ovComp,
  input wire logic [15:0] voutCmd,
  input wire logic voutCmdValid,
  input wire logic [15:0] ovLimit,
  input wire logic ovLimitValid,
  input wire logic [15:0] voutTelemetry,
  input wire logic [15:0] ovWarnLimit,
  input wire logic [15:0] uvWarnLimit,
  input wire logic [15:0] uvFaultLimit,
  input wire logic [7:0] dutyRequest,
  input wire logic precharged,
  input wire logic startupLow,
  output logic hsOn1,
  output logic hsOn2,
  output logic lsOn1,
  output logic lsOn2,
  output logic outputGoodFlag,
  output logic softStartRun,
  output logic isSlave,
  output logic [11:0] phaseOffset,
  output logic [15:0] voutTarget,
  output logic [7:0] switchPeriod,
  output logic [6:0] ocLimitEff,
  output logic [1:0] ovSelect,
  output logic overcurrentGuard,
  output logic overvoltageGuard,
  output logic ovWarn,
  output logic uvWarn,
  output logic uvFault
);

  bps_pwm_if pwm ();

  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic [4:0] syncA_reg;  // first stage, read only by second
  logic [4:0] syncB_reg;  // second stage, safe to use
  logic [3:0] strapSync_reg;
  logic [3:0] strapA_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncA_reg <= 5'h00;
      syncB_reg <= 5'h00;
      strapA_reg <= 4'h0;
      strapSync_reg <= 4'h0;
    end else begin
      syncA_reg <= {precharged, syncCurrentZero, ovComp, ocSense, enablePin};
      syncB_reg <= syncA_reg;
      strapA_reg <= phaseStrapInput;
      strapSync_reg <= strapA_reg;
    end
  end
  logic enSync;
  logic ocSync;
  logic ovSync;
  logic zeroSync;
  logic preSync;
  // floating enable is pulled low outside, so low reads as off
  assign enSync = syncB_reg[0];
  assign ocSync = syncB_reg[1];
  assign ovSync = syncB_reg[2];
  assign zeroSync = syncB_reg[3];
  assign preSync = syncB_reg[4];

  // ****************************************************
  // strap capture after reset release
  // ****************************************************
  // the strap is sampled once; later changes are ignored
  logic [1:0] strapWait_reg;
  logic strapDone_reg;
  logic [3:0] strap_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strapWait_reg <= 2'h0;
      strapDone_reg <= 1'b0;
      strap_reg <= 4'h0;
    end else if (!strapDone_reg) begin
      strapWait_reg <= strapWait_reg + 2'h1;
      if (strapWait_reg == 2'h3) begin
        strapDone_reg <= 1'b1;
        strap_reg <= strapSync_reg;
      end
    end
  end

  // ****************************************************
  // strap decode tables
  // ****************************************************
  logic [15:0] strapVout;
  logic [7:0] strapPeriod;
  logic useVoutTable;
  always_comb begin
    isSlave = 1'b0;
    phaseOffset = 12'h000;
    strapVout = bps_pkg::Mv600;
    strapPeriod = bps_pkg::Per625;
    useVoutTable = 1'b0;
    unique case (strap_reg)
      4'h0: useVoutTable = 1'b1;
      4'h1: begin
        isSlave = 1'b1;
        phaseOffset = bps_pkg::Ph180;
      end
      4'h2: begin
        isSlave = 1'b1;
        phaseOffset = bps_pkg::Ph120;
      end
      4'h3: begin
        isSlave = 1'b1;
        phaseOffset = bps_pkg::Ph90;
      end
      4'h4: begin
        isSlave = 1'b1;
        phaseOffset = bps_pkg::Ph72;
      end
      4'h5: begin
        isSlave = 1'b1;
        phaseOffset = bps_pkg::Ph60;
      end
      4'h6: begin
        isSlave = 1'b1;
        phaseOffset = bps_pkg::Ph514;
      end
      4'h7: begin
        isSlave = 1'b1;
        phaseOffset = bps_pkg::Ph45;
      end
      4'h8: strapPeriod = bps_pkg::Per1500;
      4'h9: begin
        strapPeriod = bps_pkg::Per1250;
        strapVout = bps_pkg::Mv1200;
      end
      4'ha: strapPeriod = bps_pkg::Per1040;
      4'hb: strapPeriod = bps_pkg::Per892;
      4'hc: begin
        strapPeriod = bps_pkg::Per781;
        strapVout = bps_pkg::Mv900;
      end
      4'hd: begin
        strapPeriod = bps_pkg::Per694;
        strapVout = bps_pkg::Mv850;
      end
      4'he: begin
        strapPeriod = bps_pkg::Per625;
        strapVout = bps_pkg::Mv800;
      end
      4'hf: begin
        strapPeriod = bps_pkg::Per568;
        strapVout = bps_pkg::Mv700;
      end
    endcase
  end

  // ****************************************************
  // commanded output voltage
  // ****************************************************
  // a serial command, once seen, replaces the strap value
  logic [15:0] voutCmd_reg;
  logic cmdSeen_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      voutCmd_reg <= 16'h0000;
      cmdSeen_reg <= 1'b0;
    end else if (voutCmdValid) begin
      voutCmd_reg <= voutCmd;
      cmdSeen_reg <= 1'b1;
    end
  end
  assign voutTarget = cmdSeen_reg ? voutCmd_reg : strapVout;

  // ****************************************************
  // frequency from strap or voltage range
  // ****************************************************
  // slaves follow the master clock; period is local fallback
  always_comb begin
    if (!useVoutTable) begin
      switchPeriod = strapPeriod;
    end else if (voutTarget < bps_pkg::Mv850) begin
      switchPeriod = bps_pkg::Per625;
    end else if (voutTarget < bps_pkg::Mv1100) begin
      switchPeriod = bps_pkg::Per781;
    end else begin
      switchPeriod = bps_pkg::Per1250;
    end
  end

  // ****************************************************
  // overcurrent limit clamp
  // ****************************************************
  assign ocLimitEff = (ocLimitCode > bps_pkg::OcMaxCode) ?
                      bps_pkg::OcMaxCode : ocLimitCode;

  // ****************************************************
  // overvoltage limit quantisation
  // ****************************************************
  // cross-multiplied; a truncating divide would round steps down
  logic [1:0] ovSel_reg;
  logic [31:0] ovRatio;  // limit times 1000
  logic [31:0] vt32;  // target, widened
  logic [1:0] ovQuant;
  always_comb begin
    ovRatio = {16'h0000, ovLimit} * 32'h0000_03e8;
    vt32 = {16'h0000, voutTarget};
    if (ovRatio <= vt32 * {20'h0, bps_pkg::OvPct1054}) begin
      ovQuant = 2'h0;  // 105 percent
    end else if (ovRatio <= vt32 * {20'h0, bps_pkg::OvPct1101}) begin
      ovQuant = 2'h1;  // 110 percent
    end else if (ovRatio <= vt32 * {20'h0, bps_pkg::OvPct1148}) begin
      ovQuant = 2'h2;  // 115 percent
    end else begin
      ovQuant = 2'h3;  // 120 percent
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovSel_reg <= bps_pkg::OvSel120;
    end else if (ovLimitValid) begin
      ovSel_reg <= ovQuant;
    end
  end
  assign ovSelect = ovSel_reg;

  // ****************************************************
  // overvoltage qualification
  // ****************************************************
  // comparator must hold high for the whole delay
  logic [7:0] ovCnt_reg;
  logic ovFault;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovCnt_reg <= 8'h00;
    end else if (!ovSync) begin
      ovCnt_reg <= 8'h00;
    end else if (ovCnt_reg != 8'(bps_pkg::OvDelayCycles)) begin
      ovCnt_reg <= ovCnt_reg + 8'h01;
    end
  end
  assign ovFault = (ovCnt_reg == 8'(bps_pkg::OvDelayCycles));

  // ****************************************************
  // overvoltage latch
  // ****************************************************
  // only a low enable or a bias reset clears it
  logic ovLatch_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovLatch_reg <= 1'b0;
    end else if (ovFault) begin
      ovLatch_reg <= 1'b1;  // set wins
    end else if (!enSync) begin
      ovLatch_reg <= 1'b0;
    end
  end
  assign overvoltageGuard = ovLatch_reg;

  // ****************************************************
  // main sequencer
  // ****************************************************
  bps_pkg::bps_state_e state_reg;
  logic [11:0] hicCnt_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= bps_pkg::BpsOff;
      hicCnt_reg <= 12'h000;
    end else if (!enSync) begin
      state_reg <= bps_pkg::BpsOff;
    end else begin
      unique case (state_reg)
        bps_pkg::BpsOff: begin
          if (preSync && strapDone_reg && !ovLatch_reg) begin
            state_reg <= bps_pkg::BpsRun;
          end
        end
        bps_pkg::BpsRun: begin
          // checked also during the ramp
          if (ocSync) begin
            state_reg <= bps_pkg::BpsOcDrain;
          end
        end
        bps_pkg::BpsOcDrain: begin
          if (zeroSync) begin
            hicCnt_reg <= 12'h000;
            state_reg <= latchOnOc ? bps_pkg::BpsLatched :
                         bps_pkg::BpsHiccup;
          end
        end
        bps_pkg::BpsHiccup: begin
          hicCnt_reg <= hicCnt_reg + 12'h001;
          if (hicCnt_reg == 12'(bps_pkg::HiccupCycles - 1)) begin
            state_reg <= bps_pkg::BpsRun;
          end
        end
        bps_pkg::BpsLatched: state_reg <= bps_pkg::BpsLatched;
      endcase
    end
  end
  assign overcurrentGuard = (state_reg == bps_pkg::BpsOcDrain) ||
                            (state_reg == bps_pkg::BpsHiccup) ||
                            (state_reg == bps_pkg::BpsLatched);

  // ****************************************************
  // pulse generator control
  // ****************************************************
  logic running;
  assign running = (state_reg == bps_pkg::BpsRun) && !ovLatch_reg;
  assign pwm.run = running;
  assign pwm.startup = startupLow;
  assign pwm.period = switchPeriod;
  assign pwm.duty = dutyRequest;
  assign pwm.forceSyncOn = (state_reg == bps_pkg::BpsOcDrain) &&
                           !ovLatch_reg && !ovFault;
  assign pwm.killAll = ovLatch_reg || ovFault;

  bps_pwm_gen u_gen (
    .clock(clock),
    .rst(rst),
    .ctl(pwm),
    .hsOn1(hsOn1),
    .hsOn2(hsOn2),
    .lsOn1(lsOn1),
    .lsOn2(lsOn2)
  );

  // ****************************************************
  // status outputs and telemetry compare
  // ****************************************************
  // telemetry is same-domain digital data, compared directly
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outputGoodFlag <= 1'b0;
      softStartRun <= 1'b0;
      ovWarn <= 1'b0;
      uvWarn <= 1'b0;
      uvFault <= 1'b0;
    end else begin
      outputGoodFlag <= running && !ovFault && !ocSync;
      softStartRun <= running && !ocSync;
      ovWarn <= voutTelemetry > ovWarnLimit;
      uvWarn <= voutTelemetry < uvWarnLimit;
      uvFault <= voutTelemetry < uvFaultLimit;
    end
  end

endmodule : bps_supervisor

/* bench/bps_checker.sv */
`timescale 1ns/1ps
// ****************************************
// protection timing checker
// ****************************************
module bps_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic enablePin,
  input wire logic latchOnOc,
  input wire logic ocSense,
  input wire logic ovComp,
  input wire logic startupLow,
  input wire logic hsOn1,
  input wire logic hsOn2,
  input wire logic lsOn1,
  input wire logic lsOn2,
  input wire logic outputGoodFlag,
  input wire logic softStartRun,
  input wire logic overcurrentGuard,
  input wire logic overvoltageGuard
);
  logic [7:0] ovCnt;   // comparator high run
  logic [12:0] offCnt; // dark cycles inside a fault
  logic [1:0] hsRun;   // length of running pulse
  logic [6:0] stCnt;   // cycles of start-up hint
  logic dark;          // every gate off
  assign dark = !(hsOn1 || hsOn2 || lsOn1 || lsOn2);
  // counters other than offCnt saturate so a long run never wraps into a false pass
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovCnt <= 8'h00;
      offCnt <= 13'h0000;
      hsRun <= 2'h0;
      stCnt <= 7'h00;
    end else begin
      ovCnt <= !ovComp ? 8'h00 : ovCnt + 8'(ovCnt != 8'hff);
      offCnt <= !overcurrentGuard ? 13'h0000 : offCnt + 13'(dark);
      hsRun <= !hsOn1 ? 2'h0 : hsRun + 2'(hsRun != 2'h3);
      stCnt <= !startupLow ? 7'h00 : stCnt + 7'(stCnt != 7'h7f);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // sense high while the sync switch conducts
  sequence ocRun;
    (ocSense && (lsOn1 || lsOn2))[*3];
  endsequence
  sequence ovHeld;
    (overvoltageGuard && enablePin)[*3];
  endsequence
  sequence ocHeld;
    (overcurrentGuard && latchOnOc && enablePin)[*3];
  endsequence
  chk_no_overlap: assert property (!(hsOn1 && hsOn2))
    else $error("high sides overlap");
  chk_ov_qualify: assert property ($rose(overvoltageGuard) |->
    ovCnt >= 8'(bps_pkg::OvDelayCycles)) else $error("ov too early");
  chk_ov_kill: assert property (overvoltageGuard |=>
    dark && !outputGoodFlag) else $error("ov left gates on");
  chk_ov_hold: assert property (ovHeld |=> overvoltageGuard)
    else $error("ov latch dropped");
  chk_oc_shutoff: assert property (overcurrentGuard[*2] |->
    !outputGoodFlag && !softStartRun && !hsOn1 && !hsOn2)
    else $error("oc left outputs up");
  chk_oc_detect: assert property (ocRun |-> ##[0:3] overcurrentGuard)
    else $error("oc not raised");
  chk_hiccup_span: assert property (
    $fell(overcurrentGuard) && enablePin && !latchOnOc |->
    offCnt >= 13'(bps_pkg::HiccupCycles - 1)) else $error("short blank");
  chk_oc_latch: assert property (ocHeld |=> overcurrentGuard)
    else $error("oc latch dropped");
  chk_en_off: assert property ((!enablePin)[*6] |-> dark)
    else $error("gates on while disabled");
  chk_min_on: assert property (stCnt > 7'h3c && hsOn1 |->
    hsRun < 2'(bps_pkg::MinOnCycles)) else $error("long start pulse");
endmodule : bps_checker

bind bps_supervisor bps_checker chk (.clock, .rst, .enablePin, .latchOnOc,
  .ocSense, .ovComp, .startupLow, .hsOn1, .hsOn2, .lsOn1, .lsOn2,
  .outputGoodFlag, .softStartRun, .overcurrentGuard, .overvoltageGuard);

/* bench/bps_power_model.sv */
`timescale 1ns/1ps
// ****************************************
// power stage and sense stand-in
// ****************************************
module bps_power_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsOn1,
  input wire logic hsOn2,
  input wire logic lsOn1,
  input wire logic lsOn2,
  input wire logic ocFault, // heavy load request
  input wire logic ovFault, // feedback overshoot request
  output logic ocSense,
  output logic syncCurrentZero,
  output logic ovComp,
  output logic precharged
);
  logic [3:0] amps; // coarse inductor current
  logic [4:0] pre;  // flying capacitor charge timer
  // a heavy load keeps current up, so drain only ends after release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amps <= 4'h0;
    end else if (hsOn1 || hsOn2) begin
      amps <= 4'hf;
    end else if ((lsOn1 || lsOn2) && !ocFault && amps != 4'h0) begin
      amps <= amps - 4'h1;
    end
  end
  // capacitor charges once, some cycles after bias comes up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) pre <= 5'h00;
    else if (pre != 5'h1f) pre <= pre + 5'h01;
  end
  // current is seen only through a conducting sync switch
  assign ocSense = ocFault && (lsOn1 || lsOn2) && amps != 4'h0;
  assign syncCurrentZero = (amps == 4'h0);
  assign ovComp = ovFault;
  assign precharged = (pre == 5'h1f);
endmodule : bps_power_model

/* bench/buck_protection_strap_ctrl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin nErrors++; \
$display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
// ****************************************
// bench: strap decode, limits, fault paths
// ****************************************
module buck_protection_strap_ctrl_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] phaseStrapInput = 4'h0;
  logic enablePin = 1'b0, latchOnOc = 1'b0, startupLow = 1'b0;
  logic voutCmdValid = 1'b0, ovLimitValid = 1'b0;
  logic ocFault = 1'b0, ovFault = 1'b0;
  logic [6:0] ocLimitCode = 7'h14;
  logic [15:0] voutCmd = 16'h0000, ovLimit = 16'h0000;
  logic [15:0] voutTelemetry = 16'h0000, ovWarnLimit = 16'h0500;
  logic [15:0] uvWarnLimit = 16'h0300, uvFaultLimit = 16'h0200;
  logic [7:0] dutyRequest = 8'h04;
  logic ocSense, syncCurrentZero, ovComp, precharged;
  logic hsOn1, hsOn2, lsOn1, lsOn2, outputGoodFlag, softStartRun;
  logic isSlave, overcurrentGuard, overvoltageGuard;
  logic ovWarn, uvWarn, uvFault;
  logic [11:0] phaseOffset;
  logic [15:0] voutTarget, ov;
  logic [7:0] switchPeriod;
  logic [6:0] ocLimitEff;
  logic [1:0] ovSelect;
  logic [2:0] w;
  integer seed = 32'hcba1;
  int nErrors = 0, nCompared = 0, hsEdges = 0, k;
  logic [11:0] phT [8] = '{12'h000, bps_pkg::Ph180, bps_pkg::Ph120,
    bps_pkg::Ph90, bps_pkg::Ph72, bps_pkg::Ph60, bps_pkg::Ph514,
    bps_pkg::Ph45};
  logic [7:0] perT [8] = '{bps_pkg::Per1500, bps_pkg::Per1250,
    bps_pkg::Per1040, bps_pkg::Per892, bps_pkg::Per781, bps_pkg::Per694,
    bps_pkg::Per625, bps_pkg::Per568};
  logic [15:0] vl [5] = '{bps_pkg::Mv700, bps_pkg::Mv850,
    bps_pkg::Mv1100, 16'h0600, bps_pkg::Mv1200};

  bps_supervisor dut (.clock, .rst, .phaseStrapInput, .enablePin,
    .latchOnOc, .ocLimitCode, .ocSense, .syncCurrentZero, .ovComp,
    .voutCmd, .voutCmdValid, .ovLimit, .ovLimitValid, .voutTelemetry,
    .ovWarnLimit, .uvWarnLimit, .uvFaultLimit, .dutyRequest, .precharged,
    .startupLow, .hsOn1, .hsOn2, .lsOn1, .lsOn2, .outputGoodFlag,
    .softStartRun, .isSlave, .phaseOffset, .voutTarget, .switchPeriod,
    .ocLimitEff, .ovSelect, .overcurrentGuard, .overvoltageGuard,
    .ovWarn, .uvWarn, .uvFault);
  bps_power_model pm (.clock, .rst, .hsOn1, .hsOn2, .lsOn1, .lsOn2,
    .ocFault, .ovFault, .ocSense, .syncCurrentZero, .ovComp, .precharged);

  initial forever #20 clock = ~clock;
  always @(posedge hsOn1) hsEdges++;

  // frequency band for a given output voltage
  function automatic logic [7:0] lkp(input logic [15:0] v);
    if (v < bps_pkg::Mv850) return bps_pkg::Per625;
    if (v < bps_pkg::Mv1100) return bps_pkg::Per781;
    return bps_pkg::Per1250;
  endfunction : lkp
  // start voltage per strap code, most codes give 0.6 V
  function automatic logic [15:0] vtOf(input logic [3:0] c);
    case (c)
      4'h9: return bps_pkg::Mv1200;
      4'hc: return bps_pkg::Mv900;
      4'hd: return bps_pkg::Mv850;
      4'he: return bps_pkg::Mv800;
      4'hf: return bps_pkg::Mv700;
      default: return bps_pkg::Mv600;
    endcase
  endfunction : vtOf
  // overvoltage step of a limit against the target, in tenths of pct
  function automatic logic [1:0] ovSel(input logic [15:0] o, v);
    logic [31:0] p;
    p = 32'(o) * 32'h3e8;
    if (p <= 32'(v) * 32'(bps_pkg::OvPct1054)) return 2'h0;
    if (p <= 32'(v) * 32'(bps_pkg::OvPct1101)) return 2'h1;
    if (p <= 32'(v) * 32'(bps_pkg::OvPct1148)) return 2'h2;
    return 2'h3;
  endfunction : ovSel
  task automatic doReset(input logic [3:0] s);
    rst <= 1'b1;
    phaseStrapInput <= s;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : doReset
  // one-cycle valid pulse, then let the registers settle
  task automatic sendCmd(input logic sel, input logic [15:0] v);
    if (sel) ovLimit <= v;
    else voutCmd <= v;
    ovLimitValid <= sel;
    voutCmdValid <= !sel;
    @(posedge clock);
    ovLimitValid <= 1'b0;
    voutCmdValid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : sendCmd
  // bounded wait, k holds the cycles spent
  task automatic waitOn(ref logic s, input logic v, input int lim);
    for (k = 0; k < lim && s !== v; k++) @(posedge clock);
  endtask : waitOn
  task summarize;
    $display("counts: %0d compared, %0d errors", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    for (int c = 0; c < 16; c++) begin
      doReset(4'(c));
      `CHK({isSlave, phaseOffset}, {c > 0 && c < 8, phT[c[2:0]] & {12{c < 8}}})
      `CHK(voutTarget, vtOf(4'(c)))
      if (c > 7) `CHK(switchPeriod, perT[c[2:0]])
      if (c == 0) `CHK(switchPeriod, bps_pkg::Per625)
      `CHK(ovSelect, 2'h3)
    end
    `CHK(hsEdges == 0, 1'b1)
    $display("test strap decode done");
    doReset(4'h0);
    foreach (vl[i]) begin
      sendCmd(1'b0, vl[i]);
      `CHK(voutTarget, vl[i])
      `CHK(switchPeriod, lkp(vl[i]))
    end
    for (int i = 0; i < 12; i++) begin
      ov = bps_pkg::Mv1200 + 16'h0001 + 16'($unsigned($random(seed)) % 32'h17c);
      sendCmd(1'b1, ov);
      `CHK(ovSelect, ovSel(ov, bps_pkg::Mv1200))
    end
    for (int i = 0; i < 8; i++) begin
      ocLimitCode <= (i < 2) ? 7'h4b + 7'(i) : 7'($random(seed));
      voutTelemetry <= (16'($random(seed)) & 16'h07fe) | 16'h0001;
      repeat (4) @(posedge clock);
      w = {voutTelemetry > ovWarnLimit, voutTelemetry < uvWarnLimit,
        voutTelemetry < uvFaultLimit};
      `CHK({ovWarn, uvWarn, uvFault}, w)
      `CHK(ocLimitEff, ocLimitCode > 7'h4b ? 7'h4b : ocLimitCode)
    end
    $display("test limits done");
    startupLow <= 1'b1;
    dutyRequest <= 8'h02 + 8'($unsigned($random(seed)) % 32'h8);
    enablePin <= 1'b1;
    repeat (300) @(posedge clock);
    `CHK(hsEdges > 0, 1'b1)
    startupLow <= 1'b0;
    repeat (100) @(posedge clock);
    ocFault <= 1'b1;
    waitOn(overcurrentGuard, 1'b1, 200);
    `CHK(overcurrentGuard, 1'b1)
    repeat (2) @(posedge clock);
    `CHK(lsOn1 | lsOn2, 1'b1)
    ocFault <= 1'b0;
    waitOn(overcurrentGuard, 1'b0, 5000);
    `CHK(k >= bps_pkg::HiccupCycles && k < bps_pkg::HiccupCycles + 40, 1'b1)
    latchOnOc <= 1'b1;
    ocFault <= 1'b1;
    waitOn(overcurrentGuard, 1'b1, 300);
    ocFault <= 1'b0;
    repeat (4500) @(posedge clock);
    `CHK(overcurrentGuard, 1'b1)
    enablePin <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK(overcurrentGuard, 1'b0)
    latchOnOc <= 1'b0;
    enablePin <= 1'b1;
    $display("test overcurrent done");
    repeat (60) @(posedge clock);
    ovFault <= 1'b1;
    waitOn(overvoltageGuard, 1'b1, 400);
    `CHK(k >= bps_pkg::OvDelayCycles && k < bps_pkg::OvDelayCycles + 8, 1'b1)
    ovFault <= 1'b0;
    repeat (300) @(posedge clock);
    `CHK({overvoltageGuard, hsOn1, hsOn2, lsOn1, lsOn2, outputGoodFlag}, 6'h20)
    enablePin <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK(overvoltageGuard, 1'b0)
    $display("test overvoltage done");
    summarize();
  end
  // watchdog, well past the roughly 9800 cycles the tests need
  initial begin
    repeat (40000) @(posedge clock);
    nErrors++;
    summarize();
  end
endmodule : buck_protection_strap_ctrl_tb_top
